/* File: rtl/lfwr_core.sv */
`timescale 1ns/100ps
module lfwr_core (
    // system side
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       supply_ok,
    // carrier side, samples valid on carrier_clk
    input  wire logic                       carrier_clk,
    input  wire logic                       above_half,
    input  wire logic                       above_target,
    // host outputs
    output logic                            wake_out_n,
    output logic                            data_out,
    // analog gain control
    output logic [lfwr_pkg::GAIN_W-1:0]     gain_step,
    output logic                            agc_active,
    output logic                            agc_settled
);

    lfwr_pkg::lfwr_sys_sync_t ss_q;
    lfwr_pkg::lfwr_sys_sync_t ss_d;
    lfwr_pkg::lfwr_sys_t      s_q;
    lfwr_pkg::lfwr_sys_t      s_d;
    lfwr_pkg::lfwr_lnk_sync_t ls_q;
    lfwr_pkg::lfwr_lnk_sync_t ls_d;
    lfwr_pkg::lfwr_lnk_t      l_q;
    lfwr_pkg::lfwr_lnk_t      l_d;
    logic                     rst_any;
    logic                     raw_gap;
    logic [lfwr_pkg::FILT_LEN-1:0] hist_n;

    // system domain synchronisers
    always_comb begin
        ss_d        = ss_q;
        ss_d.por_s1 = supply_ok;
        ss_d.por_s2 = ss_q.por_s1;
        ss_d.ack_s1 = l_q.ack;
        ss_d.ack_s2 = ss_q.ack_s1;
        ss_d.tgl_s1 = l_q.tgl;
        ss_d.tgl_s2 = ss_q.tgl_s1;
        ss_d.dat_s1 = l_q.dat;
        ss_d.dat_s2 = ss_q.dat_s1;
    end

    always_ff @(posedge clock) begin
        ss_q <= ss_d;
    end

    // pin reset or low supply both reset the block
    assign rst_any = rst | ~ss_q.por_s2; // R19 R21

    // system domain: reset handshake, wake latch, data output
    always_comb begin
        s_d = s_q;
        if (rst_any) begin
            s_d.req      = 1'b1; // R18
            s_d.tgl_seen = 1'b0;
            s_d.woke     = 1'b0;
            s_d.wake_n   = 1'b1; // R22
            s_d.data     = 1'b1; // R13
        end else begin
            if (s_q.req && ss_q.ack_s2) begin
                s_d.req = 1'b0;
            end
            if (s_q.req) begin
                s_d.tgl_seen = ss_q.tgl_s2;
                s_d.woke     = 1'b0;
            end else if (ss_q.tgl_s2 != s_q.tgl_seen) begin
                s_d.tgl_seen = ss_q.tgl_s2;
                s_d.woke     = 1'b1; // R16
            end
            s_d.wake_n = ~s_d.woke; // R17 R20
            s_d.data   = s_d.woke ? ss_q.dat_s2 : 1'b1; // R13 R15 R22
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign wake_out_n = s_q.wake_n;
    assign data_out   = s_q.data;

    // carrier domain reset request synchroniser
    always_comb begin
        ls_d        = ls_q;
        ls_d.req_s1 = s_q.req;
        ls_d.req_s2 = ls_q.req_s1;
    end

    always_ff @(posedge carrier_clk) begin
        ls_q <= ls_d;
    end

    // conditioner: high while carrier stays below the half level
    assign raw_gap = ~above_half; // R09
    assign hist_n  = {l_q.hist[lfwr_pkg::FILT_LEN-2:0], raw_gap};

    // carrier domain: filter, preamble count, gain loop, wake event
    always_comb begin
        l_d = l_q;
        if (ls_q.req_s2) begin
            l_d.st         = lfwr_pkg::ST_LISTEN; // R18
            l_d.hist       = lfwr_pkg::FILT_ONES;
            l_d.filt       = 1'b1;
            l_d.pre_cnt    = '0;
            l_d.settle_cnt = '0;
            l_d.settled    = 1'b0;
            l_d.hi_cnt     = '0;
            l_d.lo_cnt     = '0;
            l_d.gain       = lfwr_pkg::GAIN_MAX; // R08
            l_d.tgl        = 1'b0;
            l_d.ack        = 1'b1;
            l_d.dat        = 1'b0;
            l_d.active     = 1'b0; // R08
        end else begin
            l_d.ack  = 1'b0;
            l_d.hist = hist_n; // R24
            // output moves only after a full run of equal samples
            if (hist_n == lfwr_pkg::FILT_ONES) begin
                l_d.filt = 1'b1; // R10 R12
            end else if (hist_n == lfwr_pkg::FILT_ZEROS) begin
                l_d.filt = 1'b0; // R10 R12
            end
            l_d.dat = ~l_d.filt; // R11 R14
            unique case (l_q.st)
                lfwr_pkg::ST_LISTEN: begin
                    l_d.gain   = lfwr_pkg::GAIN_MAX; // R08
                    l_d.hi_cnt = '0;
                    l_d.lo_cnt = '0;
                    if (l_d.filt) begin
                        l_d.pre_cnt = '0; // R01 R02
                    end else if (l_q.pre_cnt == lfwr_pkg::PRE_LAST) begin
                        l_d.st = lfwr_pkg::ST_QUAL; // R01 R03
                    end else begin
                        l_d.pre_cnt = l_q.pre_cnt + 1'b1; // R01
                    end
                end
                lfwr_pkg::ST_QUAL: begin
                    if (l_d.filt) begin
                        l_d.st  = lfwr_pkg::ST_WOKE; // R05 R16
                        l_d.tgl = ~l_q.tgl; // R16
                    end
                end
                lfwr_pkg::ST_WOKE: begin
                    l_d.st = lfwr_pkg::ST_WOKE; // R17
                end
                default: begin
                    l_d.st = lfwr_pkg::ST_LISTEN;
                end
            endcase
            // registered copy of the loop-running decode
            l_d.active = (l_d.st != lfwr_pkg::ST_LISTEN); // R03 R08
            if (l_q.st != lfwr_pkg::ST_LISTEN) begin
                if (above_target) begin
                    l_d.lo_cnt = '0;
                    if (l_q.hi_cnt == lfwr_pkg::HI_LAST) begin
                        l_d.hi_cnt = '0;
                        if (l_q.gain != lfwr_pkg::GAIN_MIN) begin
                            l_d.gain = l_q.gain - lfwr_pkg::GAIN_ONE; // R06
                        end
                    end else begin
                        l_d.hi_cnt = l_q.hi_cnt + 1'b1; // R06
                    end
                end else begin
                    l_d.hi_cnt = '0;
                    if (l_q.lo_cnt == lfwr_pkg::LO_LAST) begin
                        l_d.lo_cnt = '0;
                        if (l_q.gain != lfwr_pkg::GAIN_MAX) begin
                            l_d.gain = l_q.gain + lfwr_pkg::GAIN_ONE; // R07
                        end
                    end else begin
                        l_d.lo_cnt = l_q.lo_cnt + 1'b1; // R07
                    end
                end
                if (l_q.settle_cnt == lfwr_pkg::SETTLE_LAST) begin
                    l_d.settled = 1'b1; // R03
                end else begin
                    l_d.settle_cnt = l_q.settle_cnt + 1'b1; // R03
                end
            end
        end
    end

    always_ff @(posedge carrier_clk) begin
        l_q <= l_d;
    end

    assign gain_step   = l_q.gain;
    assign agc_active  = l_q.active;
    assign agc_settled = l_q.settled;

endmodule

/* File: rtl/lfwr_pkg.sv */
// Contract
// R01 - preamble valid after 192 uninterrupted periods
// R02 - filtered dropouts do not restart count
// R03 - gain loop starts after preamble, settles 512
// R04 - transmitter sends at least 704 preamble periods
// R05 - first gap ends preamble, starts data
// R06 - two periods above target lowers gain
// R07 - eight periods below target raises gain
// R08 - standby: gain loop off, gain maximum
// R09 - below half level gives 1, above 0
// R10 - filter hides half-wave spaces, dropouts, glitches
// R11 - one filtered signal feeds data, wake, counter
// R12 - filter delay three to six periods
// R13 - standby: data output disabled, held high
// R14 - enabled data: 1 carrier, 0 gap
// R15 - data passed through undecoded
// R16 - first gap after preamble: wake low, data on
// R17 - wake stays low until reset
// R18 - reset clears counters, enters standby listen
// R19 - supply monitor holds reset while supply low
// R20 - only reset returns woken device to standby
// R21 - reset held high keeps device idle
// R22 - standby: data and wake outputs high
// R23 - host pulses reset before its own sleep
// R24 - timing counted on recovered carrier edges
package lfwr_pkg;

    localparam int unsigned PRE_PERIODS    = 192;
    localparam int unsigned SETTLE_PERIODS = 512;
    localparam int unsigned HI_PERIODS     = 2;
    localparam int unsigned LO_PERIODS     = 8;
    localparam int unsigned FILT_LEN       = 4;

    localparam int unsigned PRE_W    = 8;
    localparam int unsigned SETTLE_W = 10;
    localparam int unsigned HI_W     = 2;
    localparam int unsigned LO_W     = 4;
    localparam int unsigned GAIN_W   = 4;

    localparam logic [PRE_W-1:0]    PRE_LAST    = PRE_W'(PRE_PERIODS - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_PERIODS - 1);
    localparam logic [HI_W-1:0]     HI_LAST     = HI_W'(HI_PERIODS - 1);
    localparam logic [LO_W-1:0]     LO_LAST     = LO_W'(LO_PERIODS - 1);
    localparam logic [GAIN_W-1:0]   GAIN_MAX    = {GAIN_W{1'b1}};
    localparam logic [GAIN_W-1:0]   GAIN_MIN    = {GAIN_W{1'b0}};
    localparam logic [GAIN_W-1:0]   GAIN_ONE    = GAIN_W'(1);
    localparam logic [FILT_LEN-1:0] FILT_ONES   = {FILT_LEN{1'b1}};
    localparam logic [FILT_LEN-1:0] FILT_ZEROS  = {FILT_LEN{1'b0}};

    typedef enum logic [1:0] {
        ST_LISTEN = 2'b00,
        ST_QUAL   = 2'b01,
        ST_WOKE   = 2'b10
    } lfwr_state_t;

    typedef struct packed {
        logic por_s1;
        logic por_s2;
        logic ack_s1;
        logic ack_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic dat_s1;
        logic dat_s2;
    } lfwr_sys_sync_t;

    typedef struct packed {
        logic req;
        logic tgl_seen;
        logic woke;
        logic wake_n;
        logic data;
    } lfwr_sys_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
    } lfwr_lnk_sync_t;

    typedef struct packed {
        lfwr_state_t         st;
        logic [FILT_LEN-1:0] hist;
        logic                filt;
        logic [PRE_W-1:0]    pre_cnt;
        logic [SETTLE_W-1:0] settle_cnt;
        logic                settled;
        logic [HI_W-1:0]     hi_cnt;
        logic [LO_W-1:0]     lo_cnt;
        logic [GAIN_W-1:0]   gain;
        logic                tgl;
        logic                ack;
        logic                dat;
        logic                active;
    } lfwr_lnk_t;

endpackage

/* File: testbench/lfwr_core_properties.sv */
`timescale 1ns/100ps
module lfwr_core_checker (
    // system side
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   supply_ok,
    // carrier side
    input wire logic                   carrier_clk,
    input wire logic                   above_half,
    input wire logic                   above_target,
    // outputs
    input wire logic                   wake_out_n,
    input wire logic                   data_out,
    input wire logic [lfwr_pkg::GAIN_W-1:0] gain_step,
    input wire logic                   agc_active,
    input wire logic                   agc_settled
);
    a_reset_idle: assert property (@(posedge clock) rst |=> wake_out_n && data_out)
        else $error("outputs not idle in reset");
    a_wake_holds: assert property (@(posedge clock) disable iff (rst || !supply_ok)
        !wake_out_n |=> !wake_out_n) else $error("wake released");
    a_idle_data_hi: assert property (@(posedge clock) disable iff (rst)
        wake_out_n |-> data_out) else $error("data live in standby");
    a_gain_idle_max: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        !agc_active |-> gain_step == lfwr_pkg::GAIN_MAX) else $error("gain not max");
    a_settle_idle: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        !agc_active |-> !agc_settled) else $error("settled while idle");
    a_gain_no_rise: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        agc_active && above_target |=> gain_step <= $past(gain_step)) else $error("gain rose");
    a_gain_no_fall: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        agc_active && !above_target |=> gain_step >= $past(gain_step)) else $error("gain fell");
    a_gain_up_step: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        agc_active && above_target ##1 (agc_active && !above_target)[*8] |=>
        gain_step == $past(gain_step) + ($past(gain_step) != lfwr_pkg::GAIN_MAX))
        else $error("gain up step wrong");
    a_gain_dn_step: assert property (@(posedge carrier_clk) disable iff (rst || !supply_ok)
        agc_active && !above_target ##1 (agc_active && above_target)[*2] |=>
        gain_step == $past(gain_step) - ($past(gain_step) != lfwr_pkg::GAIN_MIN))
        else $error("gain down step wrong");
    c_woke: cover property (@(posedge clock) $fell(wake_out_n));
    c_settled: cover property (@(posedge carrier_clk) $rose(agc_settled));
    c_gain_low: cover property (@(posedge carrier_clk) gain_step < lfwr_pkg::GAIN_MAX);
endmodule
bind lfwr_core lfwr_core_checker u_lfwr_core_checker (.clock(clock), .rst(rst),
    .supply_ok(supply_ok), .carrier_clk(carrier_clk), .above_half(above_half),
    .above_target(above_target), .wake_out_n(wake_out_n), .data_out(data_out),
    .gain_step(gain_step), .agc_active(agc_active), .agc_settled(agc_settled));

/* File: testbench/lfwr_tx_model.sv */
`timescale 1ns/100ps
module lfwr_tx_model (
    // bench control
    input  wire logic run,
    input  wire logic car,
    input  wire logic tgt,
    // carrier side
    output logic      carrier_clk,
    output logic      above_half,
    output logic      above_target
);
    initial begin
        carrier_clk = 1'b0;
        above_half = 1'b0;
        above_target = 1'b0;
        forever begin
            #62.5;
            carrier_clk = run;
            #62.5;
            carrier_clk = 1'b0;
            above_half = car;
            above_target = tgt;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic       clock, rst, supply_ok, run, car, tgt;
    logic       carrier_clk, above_half, above_target;
    logic       wake_out_n, data_out, agc_active, agc_settled;
    logic [3:0] gain_step;
    int         mismatches, tests_run;
    int         cycles = 0;

    lfwr_tx_model u_lfwr_tx_model (.run(run), .car(car), .tgt(tgt), .carrier_clk(carrier_clk),
        .above_half(above_half), .above_target(above_target));
    lfwr_core u_lfwr_core (.clock(clock), .rst(rst), .supply_ok(supply_ok),
        .carrier_clk(carrier_clk), .above_half(above_half), .above_target(above_target),
        .wake_out_n(wake_out_n), .data_out(data_out), .gain_step(gain_step),
        .agc_active(agc_active), .agc_settled(agc_settled));

    task automatic test_done();
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(logic [3:0] got, logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // set carrier and target, then wait n carrier periods
    task automatic cp(int n, logic c, logic t);
        @(posedge carrier_clk);
        @(negedge clock);
        car = c;
        tgt = t;
        repeat (n) @(posedge carrier_clk);
        repeat (5) @(negedge clock);
    endtask
    task automatic t_power();
        @(negedge clock) supply_ok = 1'b0;
        cp(250, 1'b1, 1'b0);
        cp(8, 1'b0, 1'b0);
        chk({3'h0, wake_out_n}, 4'h1);
        @(negedge clock) supply_ok = 1'b1;
        cp(10, 1'b0, 1'b0);
        chk({wake_out_n, data_out, agc_active, 1'b0}, 4'hc);
        chk(gain_step, lfwr_pkg::GAIN_MAX);
    endtask
    task automatic t_preamble();
        cp(150, 1'b1, 1'b0);
        cp(10, 1'b0, 1'b0);
        cp(100, 1'b1, 1'b0);
        chk({3'h0, agc_active}, 4'h0);
        cp(2, 1'b0, 1'b0);
        cp(100, 1'b1, 1'b0);
        chk({3'h0, agc_active}, 4'h1);
    endtask
    task automatic t_gain();
        cp(6, 1'b1, 1'b1);
        chk(gain_step, 4'hc);
        cp(16, 1'b1, 1'b0);
        chk(gain_step, 4'he);
        cp(512, 1'b1, 1'b0);
        chk({3'h0, agc_settled}, 4'h1);
    endtask
    task automatic t_wake();
        cp(8, 1'b0, 1'b0);
        chk({wake_out_n, data_out}, 4'h0);
        cp(3, 1'b1, 1'b0);
        chk({3'h0, data_out}, 4'h0);
        cp(3, 1'b1, 1'b0);
        chk({3'h0, data_out}, 4'h1);
        cp(2, 1'b0, 1'b0);
        chk({3'h0, data_out}, 4'h1);
        cp(20, 1'b0, 1'b0);
        chk({wake_out_n, data_out}, 4'h0);
    endtask
    task automatic t_hold();
        @(negedge clock) rst = 1'b1;
        cp(250, 1'b1, 1'b0);
        cp(8, 1'b0, 1'b0);
        chk({wake_out_n, data_out, agc_active, 1'b0}, 4'hc);
        @(negedge clock) rst = 1'b0;
        cp(230, 1'b1, 1'b0);
        chk({3'h0, agc_active}, 4'h1);
        cp(8, 1'b0, 1'b0);
        chk({wake_out_n, data_out}, 4'h0);
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        {rst, supply_ok, run, car, tgt} = 5'h1c;
        mismatches = 0;
        tests_run = 0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        t_power();
        t_preamble();
        t_gain();
        t_wake();
        t_hold();
        test_done();
    end
endmodule
